// ==== ldc_regs.svh ====
// Register map, field positions, reset values and timing constants
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

`define LDC_A_CTRL     8'h00
`define LDC_A_LIMIT    8'h04
`define LDC_A_STAIR    8'h08
`define LDC_A_CURVE    8'h0c
`define LDC_A_FADE1    8'h10
`define LDC_A_FADE2    8'h14
`define LDC_A_SLUMBER  8'h18
`define LDC_A_DELAY    8'h1c
`define LDC_A_SCENE    8'h20
`define LDC_A_UPOINT   8'h24
`define LDC_A_STATUS   8'h28

`define LDC_F_COLOR    2:0
`define LDC_F_CURVE    4:3
`define LDC_F_LOCKPOL  5
`define LDC_F_ONDELAY  6
`define LDC_F_RETRIG   7
`define LDC_F_OFFOPT   10:8
`define LDC_F_ORSEL    14:11
`define LDC_F_GAMMA    23:15
`define LDC_F_B0       7:0
`define LDC_F_B1       15:8
`define LDC_F_B2       23:16
`define LDC_F_B3       31:24
`define LDC_F_SEL      3:0
`define LDC_F_SMODE    5:4

`define LDC_RST_CTRL   32'h0032_0020
`define LDC_RST_LIMIT  16'hff00
`define LDC_RST_CURVE  24'h00_8000
`define LDC_RST_STAIR  32'h0000_ffff

`define LDC_CLK_NS     40
`define LDC_STEP_NS    390625
`define LDC_SEC_NS     1000000000
`define LDC_OR_UNLIM   4'hf
`endif

// ==== ldc_pkg.sv ====
// Types shared by the dimmer channel control block
package ldc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ON     = 4'h2,
        ST_DELAY  = 4'h4,
        ST_ORIENT = 4'h8
    } ldc_stair_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [6:0] num;
        logic [7:0] val;
    } ldc_scene_t;

    typedef struct packed {
        logic        stair_stb;
        logic        stair_val;
        logic        daynight_stb;
        logic        daynight_val;
        logic        color_stb;
        logic [23:0] color;
        logic        scene_stb;
        logic        scene_learn;
        logic [5:0]  scene_num;
        logic        slumber_stb;
        logic        slumber_val;
        logic        lock_stb;
        logic        lock_val;
        logic        prio_sw_stb;
        logic        prio_sw_val;
        logic        prio_rel_stb;
        logic [3:0]  prio_rel;
        logic        prio_abs_stb;
        logic [7:0]  prio_abs;
    } ldc_cmd_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ldc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ldc_apb_rsp_t;

    typedef struct packed {
        logic [31:0]           ctrl;
        logic [15:0]           limit;
        logic [31:0]           stair;
        logic [23:0]           curve;
        logic [31:0]           fade1;
        logic [31:0]           fade2;
        logic [31:0]           slumber;
        logic [23:0]           delay;
        logic [3:0]            sel;
        ldc_scene_t [15:0]     scn;
        logic [8:0][7:0]       upts;
        logic [7:0]            level;
        logic [7:0]            target;
        logic [7:0]            fade;
        logic [7:0]            step_cnt;
        logic [13:0]           tick_cnt;
        logic [24:0]           sec_cnt;
        logic [15:0]           tmr;
        ldc_stair_t            st;
        logic                  day;
        logic                  lock_in;
        logic                  slum_seen;
        logic                  slum_dir;
        logic [31:0]           prdata;
        logic [7:0]            pwm_cnt;
        logic [7:0]            duty;
        logic                  pwm;
    } ldc_state_t;
endpackage

// ==== ldc_channel.sv ====
// Dimmer channel control: commands, staircase, scenes, curve and APB
`timescale 1ns/1ps
`default_nettype none
`include "ldc_regs.svh"
module ldc_channel #(
    parameter int STEP_CYC = `LDC_STEP_NS / `LDC_CLK_NS,
    parameter int SEC_CYC  = `LDC_SEC_NS / `LDC_CLK_NS
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire ldc_pkg::ldc_apb_req_t apb_i,
    output      ldc_pkg::ldc_apb_rsp_t apb_o,
    input  wire ldc_pkg::ldc_cmd_t  cmd_i,
    output      logic [7:0]         dim_level_o,
    output      logic               status_on_o,
    output      logic [7:0]         pwm_duty_o,
    output      logic               pwm_o
);
    localparam logic [8:0][7:0] LOG_PTS = {8'hff, 8'h80, 8'h40, 8'h20,
        8'h10, 8'h08, 8'h04, 8'h02, 8'h00};

    ldc_pkg::ldc_state_t state_ff;
    ldc_pkg::ldc_state_t nxt_state;

    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic        locked;
    logic        step_tick;
    logic        sec_tick;
    logic        req;
    logic [7:0]  req_tgt;
    logic [7:0]  req_fade;
    logic        go_off;
    logic        go_orient;
    logic        start_delay;
    logic [7:0]  cmin;
    logic [7:0]  cmax;
    logic [7:0]  cval;
    logic [7:0]  on_val;
    logic [7:0]  off_val;
    logic        hit;
    logic [3:0]  hit_idx;
    logic [15:0] orient_secs;
    logic [7:0]  curve_out;
    logic [8:0][7:0] pts;
    logic [6:0][7:0] pw;
    logic [2:0]  gi;
    logic [6:0]  gf;
    logic signed [15:0] dlt;
    logic [15:0] prod;
    logic [8:0]  sum;

    assign setup  = apb_i.psel && !apb_i.penable;
    assign wr_en  = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign mapped = apb_i.paddr[1:0] == 2'h0 && apb_i.paddr <= `LDC_A_STATUS;
    // Zero wait state: read data is captured in the setup cycle
    assign apb_o.pready  = 1'b1;
    assign apb_o.pslverr = apb_i.psel && apb_i.penable && !mapped;
    assign apb_o.prdata  = state_ff.prdata;

    assign dim_level_o = state_ff.level;
    assign status_on_o = state_ff.level != 8'h00;
    assign pwm_duty_o  = state_ff.duty;
    assign pwm_o       = state_ff.pwm;

    assign locked = state_ff.lock_in == state_ff.ctrl[`LDC_F_LOCKPOL];
    assign step_tick = state_ff.tick_cnt == 14'(STEP_CYC - 1);
    assign sec_tick  = state_ff.sec_cnt == 25'(SEC_CYC - 1);
    assign cmin = state_ff.limit[`LDC_F_B0];
    assign cmax = state_ff.limit[`LDC_F_B1];
    assign on_val  = state_ff.day ? state_ff.stair[`LDC_F_B0]
                                  : state_ff.stair[`LDC_F_B1];
    assign off_val = state_ff.day ? state_ff.stair[`LDC_F_B2]
                                  : state_ff.stair[`LDC_F_B3];

    // Colour value to brightness, then clamp
    always_comb begin
        unique case (state_ff.ctrl[`LDC_F_COLOR])
            3'h1: cval = cmd_i.color[15:8];
            3'h2: cval = cmd_i.color[7:0];
            3'h3: begin
                cval = cmd_i.color[23:16];
                if (cmd_i.color[15:8] < cval) cval = cmd_i.color[15:8];
                if (cmd_i.color[7:0] < cval) cval = cmd_i.color[7:0];
            end
            3'h4: begin
                cval = cmd_i.color[23:16];
                if (cmd_i.color[15:8] > cval) cval = cmd_i.color[15:8];
                if (cmd_i.color[7:0] > cval) cval = cmd_i.color[7:0];
            end
            default: cval = cmd_i.color[23:16];
        endcase
        if (cval < cmin) cval = cmin;
        if (cval > cmax) cval = cmax;
    end

    always_comb begin
        unique case (state_ff.ctrl[`LDC_F_ORSEL])
            4'h1: orient_secs = 16'h0001;
            4'h2: orient_secs = 16'h0002;
            4'h3: orient_secs = 16'h0005;
            4'h4: orient_secs = 16'h000a;
            4'h5: orient_secs = 16'h001e;
            4'h6: orient_secs = 16'h003c;
            4'h7: orient_secs = 16'h0078;
            4'h8: orient_secs = 16'h012c;
            4'h9: orient_secs = 16'h0258;
            4'ha: orient_secs = 16'h04b0;
            4'hb: orient_secs = 16'h0708;
            4'hc: orient_secs = 16'h0e10;
            4'hd: orient_secs = 16'h1c20;
            default: orient_secs = 16'h0000;
        endcase
    end

    // First enabled slot with a matching number wins
    always_comb begin
        hit = 1'b0;
        hit_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (state_ff.scn[i].mode != 2'h0 &&
                state_ff.scn[i].num == {1'b0, cmd_i.scene_num} + 7'h01) begin
                hit = 1'b1;
                hit_idx = 4'(i);
            end
        end
    end

    // Dimming curve; the gamma power is rounded per multiply
    always_comb begin
        pts = state_ff.ctrl[`LDC_F_CURVE] == 2'h2 ? state_ff.upts : LOG_PTS;
        dlt = 16'(signed'({8'h00, pts[state_ff.level[7:5] + 4'h1]})) -
              16'(signed'({8'h00, pts[state_ff.level[7:5]]}));
        dlt = (dlt * signed'({11'h000, state_ff.level[4:0]})) >>> 5;
        pw[0] = 8'hff;
        for (int k = 1; k < 7; k++) begin
            pw[k] = 8'(({8'h00, pw[k-1]} * {8'h00, state_ff.level}
                        + 16'h00ff) >> 8);
        end
        gi = 3'(state_ff.ctrl[`LDC_F_GAMMA] / 9'h064);
        gf = 7'(state_ff.ctrl[`LDC_F_GAMMA] % 9'h064);
        if (gi > 3'h5) gi = 3'h5;
        if (gi == 3'h5) gf = 7'h00;
        unique case (state_ff.ctrl[`LDC_F_CURVE])
            2'h0: curve_out = state_ff.level;
            2'h3: curve_out = pw[gi] - 8'((({8'h00, pw[gi] - pw[gi + 3'h1]}
                      * {9'h000, gf}) / 16'h0064));
            default: curve_out = 8'(16'(signed'({8'h00,
                      pts[state_ff.level[7:5]]})) + dlt);
        endcase
        prod = {8'h00, curve_out} * {8'h00, state_ff.curve[`LDC_F_B1]};
        prod = prod >> 7;
        if (prod > 16'h00ff) prod = 16'h00ff;
        sum = {1'b0, prod[7:0]} + {1'b0, state_ff.curve[`LDC_F_B2]};
        if (sum[8]) sum = 9'h0ff;
        if (state_ff.level == 8'h00) sum = 9'h000;
    end

    always_comb begin
        nxt_state = state_ff;
        req = 1'b0;
        req_tgt = state_ff.level;
        req_fade = 8'h00;
        go_off = 1'b0;
        go_orient = 1'b0;
        start_delay = 1'b0;

        if (setup) begin
            unique case (apb_i.paddr)
                `LDC_A_CTRL:    nxt_state.prdata = state_ff.ctrl;
                `LDC_A_LIMIT:   nxt_state.prdata = {16'h0000, state_ff.limit};
                `LDC_A_STAIR:   nxt_state.prdata = state_ff.stair;
                `LDC_A_CURVE:   nxt_state.prdata = {8'h00, state_ff.curve};
                `LDC_A_FADE1:   nxt_state.prdata = state_ff.fade1;
                `LDC_A_FADE2:   nxt_state.prdata = state_ff.fade2;
                `LDC_A_SLUMBER: nxt_state.prdata = state_ff.slumber;
                `LDC_A_DELAY:   nxt_state.prdata = {8'h00, state_ff.delay};
                `LDC_A_SCENE:   nxt_state.prdata = {8'h00,
                    state_ff.scn[state_ff.sel].val, 1'b0,
                    state_ff.scn[state_ff.sel].num, 2'h0,
                    state_ff.scn[state_ff.sel].mode, state_ff.sel};
                `LDC_A_STATUS:  nxt_state.prdata = {state_ff.duty, 2'h0,
                    locked, state_ff.day, state_ff.st, state_ff.target,
                    state_ff.level};
                default:        nxt_state.prdata = 32'h0000_0000;
            endcase
        end
        if (wr_en) begin
            unique case (apb_i.paddr)
                `LDC_A_CTRL:    nxt_state.ctrl = apb_i.pwdata;
                `LDC_A_LIMIT:   nxt_state.limit = apb_i.pwdata[15:0];
                `LDC_A_STAIR:   nxt_state.stair = apb_i.pwdata;
                `LDC_A_CURVE:   nxt_state.curve = apb_i.pwdata[23:0];
                `LDC_A_FADE1:   nxt_state.fade1 = apb_i.pwdata;
                `LDC_A_FADE2:   nxt_state.fade2 = apb_i.pwdata;
                `LDC_A_SLUMBER: nxt_state.slumber = apb_i.pwdata;
                `LDC_A_DELAY:   nxt_state.delay = apb_i.pwdata[23:0];
                `LDC_A_SCENE: begin
                    nxt_state.sel = apb_i.pwdata[`LDC_F_SEL];
                    nxt_state.scn[apb_i.pwdata[`LDC_F_SEL]] = {
                        apb_i.pwdata[`LDC_F_SMODE], apb_i.pwdata[14:8],
                        apb_i.pwdata[`LDC_F_B2]};
                end
                `LDC_A_UPOINT: begin
                    if (apb_i.pwdata[3:0] < 4'h9) begin
                        nxt_state.upts[apb_i.pwdata[3:0]] =
                            apb_i.pwdata[`LDC_F_B1];
                    end
                end
                default: ;
            endcase
        end

        nxt_state.tick_cnt = step_tick ? 14'h0000 : state_ff.tick_cnt + 14'h1;
        nxt_state.sec_cnt = sec_tick ? 25'h0 : state_ff.sec_cnt + 25'h1;
        if (cmd_i.lock_stb) nxt_state.lock_in = cmd_i.lock_val;
        if (cmd_i.daynight_stb) nxt_state.day = cmd_i.daynight_val;

        if (!locked) begin
            if (cmd_i.color_stb) begin
                req = 1'b1;
                req_tgt = cval;
                req_fade = cval > state_ff.level ? state_ff.slumber[`LDC_F_B2]
                                                 : state_ff.slumber[`LDC_F_B3];
            end
            if (cmd_i.stair_stb && cmd_i.stair_val) begin
                req = 1'b1;
                req_tgt = on_val;
                req_fade = state_ff.fade1[`LDC_F_B0];
                if (!state_ff.ctrl[`LDC_F_ONDELAY]) begin
                    nxt_state.st = ldc_pkg::ST_ON;
                end else if (state_ff.st != ldc_pkg::ST_DELAY ||
                             state_ff.ctrl[`LDC_F_RETRIG]) begin
                    start_delay = 1'b1;
                end
            end
            if (cmd_i.stair_stb && !cmd_i.stair_val) begin
                unique case (state_ff.ctrl[`LDC_F_OFFOPT])
                    3'h1: go_off = 1'b1;
                    3'h2: start_delay = state_ff.st != ldc_pkg::ST_DELAY ||
                                        state_ff.ctrl[`LDC_F_RETRIG];
                    3'h3: go_orient = 1'b1;
                    3'h4: begin
                        go_off = state_ff.st == ldc_pkg::ST_ORIENT;
                        go_orient = state_ff.st != ldc_pkg::ST_ORIENT;
                    end
                    default: ;
                endcase
            end
            if (!cmd_i.stair_stb && sec_tick) begin
                if (state_ff.st == ldc_pkg::ST_DELAY) begin
                    if (state_ff.tmr <= 16'h0001) begin
                        go_orient = orient_secs != 16'h0000 ||
                            state_ff.ctrl[`LDC_F_ORSEL] == `LDC_OR_UNLIM;
                        go_off = !go_orient;
                    end else begin
                        nxt_state.tmr = state_ff.tmr - 16'h0001;
                    end
                end else if (state_ff.st == ldc_pkg::ST_ORIENT &&
                        state_ff.ctrl[`LDC_F_ORSEL] != `LDC_OR_UNLIM) begin
                    if (state_ff.tmr <= 16'h0001) go_off = 1'b1;
                    else nxt_state.tmr = state_ff.tmr - 16'h0001;
                end
            end
            if (go_orient && orient_secs == 16'h0000 &&
                state_ff.ctrl[`LDC_F_ORSEL] != `LDC_OR_UNLIM) begin
                go_orient = 1'b0;
                go_off = 1'b1;
            end
            if (start_delay) begin
                nxt_state.st = ldc_pkg::ST_DELAY;
                nxt_state.tmr = state_ff.delay[15:0];
            end
            if (go_orient) begin
                nxt_state.st = ldc_pkg::ST_ORIENT;
                nxt_state.tmr = orient_secs;
                req = 1'b1;
                req_tgt = state_ff.curve[`LDC_F_B0];
                req_fade = state_ff.fade1[`LDC_F_B2];
            end
            if (go_off) begin
                nxt_state.st = ldc_pkg::ST_IDLE;
                req = 1'b1;
                req_tgt = off_val;
                req_fade = state_ff.fade1[`LDC_F_B1];
            end
            if (cmd_i.slumber_stb) begin
                nxt_state.slum_seen = 1'b1;
                nxt_state.slum_dir = cmd_i.slumber_val;
                req = 1'b1;
                if (cmd_i.slumber_val) begin
                    req_tgt = state_ff.slumber[`LDC_F_B0];
                    req_fade = (state_ff.slum_seen && state_ff.slum_dir)
                        ? state_ff.fade2[`LDC_F_B1]
                        : state_ff.fade2[`LDC_F_B0];
                end else begin
                    req_tgt = state_ff.slumber[`LDC_F_B1];
                    req_fade = (state_ff.slum_seen && !state_ff.slum_dir)
                        ? state_ff.fade2[`LDC_F_B3]
                        : state_ff.fade2[`LDC_F_B2];
                end
            end
            if (cmd_i.scene_stb && hit) begin
                if (cmd_i.scene_learn) begin
                    if (state_ff.scn[hit_idx].mode == 2'h2) begin
                        nxt_state.scn[hit_idx].val = state_ff.level;
                    end
                end else begin
                    req = 1'b1;
                    req_tgt = state_ff.scn[hit_idx].val;
                    req_fade = state_ff.fade1[`LDC_F_B3];
                end
            end
        end else begin
            // Locked: the staircase is dropped and its timers stop
            nxt_state.st = ldc_pkg::ST_IDLE;
        end

        // Priority inputs act whether or not the lock is engaged
        if (cmd_i.prio_sw_stb) begin
            req = 1'b1;
            req_tgt = cmd_i.prio_sw_val ? 8'hff : 8'h00;
            req_fade = state_ff.delay[`LDC_F_B2];
        end
        if (cmd_i.prio_rel_stb) begin
            req = 1'b1;
            req_fade = state_ff.delay[`LDC_F_B2];
            if (cmd_i.prio_rel[2:0] == 3'h0) req_tgt = state_ff.level;
            else req_tgt = cmd_i.prio_rel[3] ? 8'hff : 8'h00;
        end
        if (cmd_i.prio_abs_stb) begin
            req = 1'b1;
            req_tgt = cmd_i.prio_abs;
            req_fade = state_ff.delay[`LDC_F_B2];
        end

        if (req) begin
            nxt_state.target = req_tgt;
            nxt_state.fade = req_fade;
            nxt_state.step_cnt = 8'h00;
        end else if (state_ff.target != state_ff.level) begin
            // One level step per fade count of step ticks
            if (state_ff.fade == 8'h00) begin
                nxt_state.level = state_ff.target;
            end else if (step_tick) begin
                if (state_ff.step_cnt + 8'h01 >= state_ff.fade) begin
                    nxt_state.step_cnt = 8'h00;
                    nxt_state.level = state_ff.target > state_ff.level
                        ? state_ff.level + 8'h01
                        : state_ff.level - 8'h01;
                end else begin
                    nxt_state.step_cnt = state_ff.step_cnt + 8'h01;
                end
            end
        end

        nxt_state.duty = sum[7:0];
        nxt_state.pwm_cnt = state_ff.pwm_cnt + 8'h01;
        nxt_state.pwm = state_ff.pwm_cnt < state_ff.duty;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= '0;
            state_ff.ctrl <= `LDC_RST_CTRL;
            state_ff.limit <= `LDC_RST_LIMIT;
            state_ff.curve <= `LDC_RST_CURVE;
            state_ff.stair <= `LDC_RST_STAIR;
            state_ff.upts <= LOG_PTS;
            state_ff.st <= ldc_pkg::ST_IDLE;
            state_ff.day <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule
`default_nettype wire

// ==== ldc_chk_properties.sv ====
// Port-level assertions for the dimmer channel control block
`timescale 1ns/1ps
`default_nettype none
module ldc_chk (
    input wire logic                  sys_clk_i,
    input wire logic                  rst_i,
    input wire ldc_pkg::ldc_apb_req_t apb_i,
    input wire ldc_pkg::ldc_apb_rsp_t apb_o,
    input wire ldc_pkg::ldc_cmd_t     cmd_i,
    input wire logic [7:0]            dim_level_o,
    input wire logic                  status_on_o,
    input wire logic [7:0]            pwm_duty_o,
    input wire logic                  pwm_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic acc;
    logic bad;
    assign acc = apb_i.psel && apb_i.penable;
    assign bad = (apb_i.paddr > 8'h28) || (apb_i.paddr[1:0] != 2'h0);
    a_zero_duty_off: assert property (dim_level_o == 8'h00 |=> pwm_duty_o == 8'h00)
        else $error("duty set at zero level");
    a_zero_pin_off: assert property (pwm_duty_o == 8'h00 |=> !pwm_o)
        else $error("pin high at zero duty");
    a_status_level: assert property (status_on_o == (dim_level_o != 8'h00))
        else $error("status differs from level");
    a_ready_high: assert property (acc |-> apb_o.pready)
        else $error("no ready in access");
    a_err_unmapped: assert property (acc && bad |-> apb_o.pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (acc && !bad |-> !apb_o.pslverr)
        else $error("error on mapped");
    a_bad_read_zero: assert property (acc && bad && !apb_i.pwrite |-> apb_o.prdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_read: assert property (acc && !apb_i.pwrite && apb_i.paddr == 8'h28 |->
        apb_o.prdata[7:0] == $past(dim_level_o) && apb_o.prdata[31:24] == $past(pwm_duty_o))
        else $error("status read mismatch");
    c_unmapped: cover property (acc && bad);
    c_orient: cover property (dim_level_o == 8'h44);
    c_pwm: cover property ($rose(pwm_o));
endmodule
`default_nettype wire

// ==== ldc_bus_model.sv ====
// Telegram source standing in for the automation bus
`timescale 1ns/1ps
`default_nettype none
module ldc_bus_model (
    input  wire logic              sys_clk_i,
    output var ldc_pkg::ldc_cmd_t  cmd_o
);
    initial cmd_o = '0;
    // Kind 0 colour, 1 staircase, 2 day/night, 3 lock, 4 priority value,
    // 5 scene (bit 8 stores), 6 slumber, 7 priority switch
    task automatic send(input int k, input logic [23:0] v);
        ldc_pkg::ldc_cmd_t c;
        c = '0;
        c.color = v;
        c.stair_val = v[0];
        c.daynight_val = v[0];
        c.lock_val = v[0];
        c.prio_abs = v[7:0];
        c.scene_num = v[5:0];
        c.scene_learn = v[8];
        c.slumber_val = v[0];
        c.prio_sw_val = v[0];
        case (k)
            0: c.color_stb = 1'b1;
            1: c.stair_stb = 1'b1;
            2: c.daynight_stb = 1'b1;
            3: c.lock_stb = 1'b1;
            5: c.scene_stb = 1'b1;
            6: c.slumber_stb = 1'b1;
            7: c.prio_sw_stb = 1'b1;
            default: c.prio_abs_stb = 1'b1;
        endcase
        @(posedge sys_clk_i);
        cmd_o <= c;
        @(posedge sys_clk_i);
        cmd_o <= '0;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the dimmer channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [2:0] m; logic [23:0] c; logic [7:0] e;} ldc_row_t;
    logic                  sys_clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    ldc_pkg::ldc_apb_req_t req = '0;
    ldc_pkg::ldc_apb_rsp_t rsp;
    ldc_pkg::ldc_cmd_t     cmd;
    logic [7:0]            lvl;
    logic                  son;
    logic [7:0]            duty;
    logic                  pwm;
    logic [31:0]           rd;
    logic                  er;
    int                    err_total = 0;
    int                    compares = 0;
    logic [31:0]           rv [4] = '{32'h0032_0020, 32'hff00, 32'hffff, 32'h8000};
    ldc_row_t              rows [7] = '{'{3'h0, 24'h409060, 8'h40},
        '{3'h1, 24'h409060, 8'h90}, '{3'h2, 24'h409060, 8'h60},
        '{3'h3, 24'h409060, 8'h40}, '{3'h4, 24'h409060, 8'h90},
        '{3'h0, 24'h10f080, 8'h20}, '{3'h4, 24'h10f080, 8'he0}};
    always #20 sys_clk_i = ~sys_clk_i;
    // Short counts keep the staircase timing within a few hundred cycles
    ldc_channel #(.STEP_CYC(2), .SEC_CYC(20)) dut (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .apb_i(req), .apb_o(rsp), .cmd_i(cmd),
        .dim_level_o(lvl), .status_on_o(son), .pwm_duty_o(duty), .pwm_o(pwm));
    ldc_bus_model u_bus (.sys_clk_i(sys_clk_i), .cmd_o(cmd));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        @(posedge sys_clk_i);
        while (rsp.pready !== 1'b1) @(posedge sys_clk_i);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    // Bounded wait; the ramp may take several edges to settle
    task automatic lvl_is(input string n, input logic [7:0] e, input int max);
        for (int i = 0; i < max && lvl !== e; i++) @(posedge sys_clk_i);
        chk(n, lvl, e);
    endtask
    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (rv[i]) begin
            apb(1'b0, 8'(i * 4), '0);
            chk("reset value", rd, rv[i]);
        end
        apb(1'b0, 8'h28, '0);
        chk("status after reset", rd, 32'h0011_0000);
        apb(1'b0, 8'h2c, '0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 8'h04, 32'h0000_e020);
        foreach (rows[i]) begin
            apb(1'b1, 8'h00, 32'h0032_0020 | 32'(rows[i].m));
            u_bus.send(0, rows[i].c);
            lvl_is("colour level", rows[i].e, 8);
        end
        apb(1'b1, 8'h08, 32'h1030_5070);
        apb(1'b1, 8'h00, 32'h0032_0120);
        u_bus.send(1, 24'h1);
        lvl_is("day on", 8'h70, 8);
        u_bus.send(2, 24'h0);
        u_bus.send(1, 24'h0);
        lvl_is("night off", 8'h10, 8);
        u_bus.send(1, 24'h1);
        lvl_is("night on", 8'h50, 8);
        u_bus.send(2, 24'h1);
        u_bus.send(1, 24'h0);
        lvl_is("day off", 8'h30, 8);
        apb(1'b1, 8'h1c, 32'h0000_0002);
        apb(1'b1, 8'h0c, 32'h0000_8044);
        apb(1'b1, 8'h00, 32'h0032_0860);
        u_bus.send(1, 24'h1);
        lvl_is("delay on", 8'h70, 8);
        lvl_is("orientation", 8'h44, 120);
        lvl_is("orientation end", 8'h30, 60);
        u_bus.send(3, 24'h1);
        u_bus.send(1, 24'h1);
        repeat (6) @(posedge sys_clk_i);
        chk("locked staircase", lvl, 8'h30);
        u_bus.send(4, 24'h33);
        lvl_is("priority locked", 8'h33, 8);
        apb(1'b0, 8'h28, '0);
        chk("lock flag", rd[21], 1'b1);
        apb(1'b1, 8'h00, 32'h0032_0000);
        u_bus.send(0, 24'h600000);
        lvl_is("lock polarity", 8'h60, 8);
        apb(1'b1, 8'h18, 32'h0000_1048);
        apb(1'b1, 8'h14, 32'h0001_0000);
        u_bus.send(6, 24'h1);
        lvl_is("slumber on", 8'h48, 8);
        u_bus.send(6, 24'h0);
        repeat (20) @(posedge sys_clk_i);
        chk("slumber ramp", lvl > 8'h10 && lvl < 8'h48, 1'b1);
        u_bus.send(6, 24'h0);
        lvl_is("slumber second", 8'h10, 4);
        apb(1'b1, 8'h20, 32'h0077_0523);
        u_bus.send(5, 24'h104);
        apb(1'b0, 8'h20, '0);
        chk("scene store", rd, 32'h0010_0523);
        apb(1'b1, 8'h0c, 32'h0010_8000);
        u_bus.send(4, 24'h40);
        lvl_is("priority level", 8'h40, 8);
        repeat (3) @(posedge sys_clk_i);
        chk("offset duty", duty, 8'h50);
        apb(1'b1, 8'h0c, 32'h0010_4000);
        repeat (3) @(posedge sys_clk_i);
        chk("gain duty", duty, 8'h30);
        chk("level kept", lvl, 8'h40);
        chk("status on", son, 1'b1);
        apb(1'b1, 8'h24, 32'h0000_9902);
        apb(1'b1, 8'h00, 32'h0032_0010);
        repeat (3) @(posedge sys_clk_i);
        chk("user curve duty", duty, 8'h5c);
        apb(1'b1, 8'h00, 32'h0032_0008);
        repeat (3) @(posedge sys_clk_i);
        chk("log curve duty", duty, 8'h12);
        apb(1'b1, 8'h00, 32'h0064_0018);
        repeat (3) @(posedge sys_clk_i);
        chk("gamma duty", duty, 8'h18);
        u_bus.send(5, 24'h4);
        lvl_is("scene recall", 8'h10, 8);
        u_bus.send(7, 24'h0);
        repeat (6) @(posedge sys_clk_i);
        chk("zero duty", duty, 8'h00);
        chk("zero pin", pwm, 1'b0);
        chk("status off", son, 1'b0);
        final_report;
    end
endmodule
bind ldc_channel ldc_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .apb_i(apb_i), .apb_o(apb_o), .cmd_i(cmd_i), .dim_level_o(dim_level_o),
    .status_on_o(status_on_o), .pwm_duty_o(pwm_duty_o), .pwm_o(pwm_o));
`default_nettype wire
